/* logic/fts_regs.sv */
// fts_regs: class word, condition word and operating setup of the fpu, plus pointers
// assumes: execution unit reports events one cycle wide; core reads/writes via sel port
// assumes: all inputs synchronous to clk; rst_b asynchronous, active low
// outputs are flop copies; reads show same-edge updates
// How it works
// - eight 2-bit classes: valid, zero, special, empty
// - denormal, infinity, NaN, unsupported classed special
// - classes follow register writes automatically
// - register n class at bits 2n+1:2n
// - bit 15 mirrors error summary bit 7
// - condition codes at 14 and 10:8
// - bits 13:11 hold stack top number
// - error summary set on unmasked exception
// - bit 6 flags stack overflow/underflow
// - bits 5:0 record six exception flags
// - condition word readable at all times
// - setup 11:10 select rounding mode
// - setup 9:8 select result precision
// - setup 5:0 mask exceptions, flag positions
// - keep instruction and operand pointers
// - fpu runs concurrently with integer core
module fts_regs #(
    parameter int NUM_REGS = fts_pkg::NUM_REGS
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // core-side register port
    input  wire logic                      reg_wr,
    input  wire logic [1:0]                reg_sel,
    input  wire logic [15:0]               reg_wdata,
    output logic [15:0]                    reg_rdata,
    // execution unit: data register write with classification inputs
    input  wire logic                      dreg_wr,
    input  wire logic [2:0]                dreg_idx,
    input  wire logic                      dreg_is_zero,
    input  wire logic                      dreg_is_denormal,
    input  wire logic                      dreg_is_inf,
    input  wire logic                      dreg_is_nan,
    input  wire logic                      dreg_is_unsupported,
    input  wire logic                      dreg_free,
    // execution unit: stack and result status
    input  wire logic                      top_wr,
    input  wire logic [2:0]                top_val,
    input  wire logic                      cc_wr,
    input  wire logic [3:0]                cc_val,
    input  wire logic [5:0]                exc_event,
    input  wire logic                      stack_fault_event,
    input  wire logic                      busy_in,
    // pointer capture at instruction issue
    input  wire logic                      instr_issue,
    input  wire logic [31:0]               instr_addr,
    input  wire logic                      operand_valid,
    input  wire logic [31:0]               operand_addr,
    // outputs to execution and core
    output logic [1:0]                     rounding_select,
    output logic [1:0]                     precision_select,
    output logic                           fpu_trap,
    output logic                           fpu_busy,
    output logic [31:0]                    instr_ptr,
    output logic [31:0]                    operand_ptr
);
    initial begin
        if (NUM_REGS != 8) $error("fts_regs supports exactly eight data registers");
        if (fts_pkg::WORD_W != 16) $error("fts_regs assumes sixteen-bit register words");
        if (fts_pkg::NUM_EXC != 6) $error("fts_regs assumes six exception flags");
        if (2 * NUM_REGS != fts_pkg::WORD_W) $error("class fields must fill one word");
        if (fts_pkg::POS_ERR_SUM != 7) $error("error summary must sit at bit 7");
        if (fts_pkg::POS_BUSY_COPY != 15) $error("summary copy must sit at bit 15");
    end

    logic [15:0] fpu_class_word;
    logic [15:0] cond_flags;      // bits 14:0; bit 15 derived
    // condition word fields, one flop group each
    logic [5:0]  exc_flags;
    logic        stack_fault_flag;
    logic        error_summary;
    logic [2:0]  stack_top;
    logic        cond_code_hi;
    logic [2:0]  cond_code_lo;
    logic [15:0] fpu_operating_setup;
    logic [15:0] fpu_condition_word;

    // class encoding from classification inputs
    function automatic logic [1:0] fts_classify(
        input logic free,
        input logic zero,
        input logic spec
    );
        if (free)
            fts_classify = fts_pkg::CLS_EMPTY;
        else if (spec)
            fts_classify = fts_pkg::CLS_SPECIAL;
        else if (zero)
            fts_classify = fts_pkg::CLS_ZERO;
        else
            fts_classify = fts_pkg::CLS_VALID;
    endfunction

    wire logic       dreg_special = dreg_is_denormal
                                    | dreg_is_inf
                                    | dreg_is_nan
                                    | dreg_is_unsupported;
    wire logic [1:0] new_class    = fts_classify(dreg_free, dreg_is_zero, dreg_special);

    // register select decode, shared by write strobes and read mux
    function automatic logic fts_sel_hit(
        input logic [1:0] sel,
        input logic [1:0] code
    );
        fts_sel_hit = (sel == code);
    endfunction

    wire logic       hit_class    = fts_sel_hit(reg_sel, fts_pkg::SEL_CLASS);
    wire logic       hit_cond     = fts_sel_hit(reg_sel, fts_pkg::SEL_COND);
    wire logic       hit_setup    = fts_sel_hit(reg_sel, fts_pkg::SEL_SETUP);
    wire logic       wr_class     = reg_wr && hit_class;
    wire logic       wr_cond      = reg_wr && hit_cond;
    wire logic       wr_setup     = reg_wr && hit_setup;

    // per-register class fields
    logic [15:0] next_class_word;
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_cls
            wire logic       hw_hit  = dreg_wr && (dreg_idx == 3'(g));
            wire logic [1:0] sw_val  = reg_wdata[2*g+1:2*g];
            wire logic [1:0] old_val = fpu_class_word[2*g+1:2*g];
            // hardware classification wins over a same-cycle software write
            assign next_class_word[2*g+1:2*g] =
                hw_hit     ? new_class
                : wr_class ? sw_val
                : old_val;
        end
    endgenerate

    // unmasked exceptions: mask bit 1 suppresses
    wire logic [5:0] exc_mask   = fpu_operating_setup[5:0];
    wire logic [5:0] unmasked   = exc_event & ~exc_mask;
    wire logic       sf_unmask  = stack_fault_event & ~exc_mask[0];
    wire logic       err_event  = |unmasked | sf_unmask;

    // status next value; hardware set wins over software write
    wire logic [15:0] cond_base = wr_cond ? {1'b0, reg_wdata[14:0]} : cond_flags;
    // each exception flag is sticky; stack fault also reports invalid
    logic [5:0] next_exc;
    genvar e;
    generate
        for (e = 0; e < fts_pkg::NUM_EXC; e++) begin : g_exc
            wire logic from_sw  = cond_base[e];
            wire logic from_exc = exc_event[e];
            wire logic from_sf  = (e == 0) ? stack_fault_event : 1'b0;
            assign next_exc[e] = from_sw | from_exc | from_sf;
        end
    endgenerate
    wire logic        next_sf   = cond_base[fts_pkg::POS_STK_FAULT] | stack_fault_event;
    wire logic        next_es   = cond_base[fts_pkg::POS_ERR_SUM] | err_event;
    wire logic [2:0]  next_top  = top_wr ? top_val : cond_base[13:11];
    wire logic        next_c3   = cc_wr ? cc_val[3] : cond_base[fts_pkg::POS_CC_HI];
    wire logic [2:0]  next_clo  = cc_wr ? cc_val[2:0] : cond_base[10:8];
    wire logic [15:0] next_cond = {
        1'b0,
        next_c3,
        next_top,
        next_clo,
        next_es,
        next_sf,
        next_exc
    };

    // reserved setup bits read back as zero
    wire logic [15:0] setup_wr_val = reg_wdata & fts_pkg::SETUP_WR_MASK;
    wire logic [15:0] next_setup   = wr_setup ? setup_wr_val : fpu_operating_setup;
    // field views of the setup word
    wire logic [1:0]  next_round   = next_setup[fts_pkg::POS_ROUND_LO +: 2];
    wire logic [1:0]  next_prec    = next_setup[fts_pkg::POS_PREC_LO +: 2];

    // assembled condition word with mirror of error summary
    assign fpu_condition_word = {next_cond[fts_pkg::POS_ERR_SUM], next_cond[14:0]};

    // reads show this edge's updates
    wire logic [15:0] next_rdata =
        hit_class   ? next_class_word
        : hit_cond  ? fpu_condition_word
        : hit_setup ? next_setup
        : 16'h0000;

    // class word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fpu_class_word <= fts_pkg::CLASS_RST;
        end else begin
            fpu_class_word <= next_class_word;
        end
    end

    // sticky exception flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            exc_flags <= fts_pkg::COND_RST[5:0];
        end else begin
            exc_flags <= next_exc;
        end
    end

    // stack fault flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stack_fault_flag <= fts_pkg::COND_RST[fts_pkg::POS_STK_FAULT];
        end else begin
            stack_fault_flag <= next_sf;
        end
    end

    // error summary
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            error_summary <= fts_pkg::COND_RST[fts_pkg::POS_ERR_SUM];
        end else begin
            error_summary <= next_es;
        end
    end

    // stack top pointer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stack_top <= fts_pkg::COND_RST[fts_pkg::POS_TOP_LO +: 3];
        end else begin
            stack_top <= next_top;
        end
    end

    // condition code high bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cond_code_hi <= fts_pkg::COND_RST[fts_pkg::POS_CC_HI];
        end else begin
            cond_code_hi <= next_c3;
        end
    end

    // condition code low bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cond_code_lo <= fts_pkg::COND_RST[fts_pkg::POS_CC_LO +: 3];
        end else begin
            cond_code_lo <= next_clo;
        end
    end

    assign cond_flags = {1'b0, cond_code_hi, stack_top, cond_code_lo, error_summary,
                         stack_fault_flag, exc_flags};

    // operating setup
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fpu_operating_setup <= fts_pkg::SETUP_RST;
        end else begin
            fpu_operating_setup <= next_setup;
        end
    end

    // outputs registered; status read never waits on busy
    wire logic        next_trap     = next_es;
    wire logic        next_busy     = busy_in;

    // read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // rounding mode, reset value follows the setup word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rounding_select <= fts_pkg::SETUP_RST[fts_pkg::POS_ROUND_LO +: 2];
        end else begin
            rounding_select <= next_round;
        end
    end

    // precision, reset value follows the setup word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            precision_select <= fts_pkg::SETUP_RST[fts_pkg::POS_PREC_LO +: 2];
        end else begin
            precision_select <= next_prec;
        end
    end

    // trap request to the core
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fpu_trap <= 1'b0;
        end else begin
            fpu_trap <= next_trap;
        end
    end

    // busy copy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fpu_busy <= 1'b0;
        end else begin
            fpu_busy <= next_busy;
        end
    end

    // pointers of current instruction and operand
    // operand pointer cleared when there is no memory operand
    wire logic        ptr_load     = instr_issue;
    wire logic [31:0] next_instr   = ptr_load ? instr_addr : instr_ptr;
    wire logic [31:0] operand_sel  = operand_valid ? operand_addr : 32'h0000_0000;
    wire logic [31:0] next_operand = ptr_load ? operand_sel : operand_ptr;

    // instruction pointer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_ptr <= 32'h0000_0000;
        end else begin
            instr_ptr <= next_instr;
        end
    end

    // operand pointer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            operand_ptr <= 32'h0000_0000;
        end else begin
            operand_ptr <= next_operand;
        end
    end
endmodule

/* common/fts_pkg.sv */
// fts_pkg: field layout, codes and reset values of the fpu tag/status/control registers
// assumes: one clock domain, registers reached through a dedicated core-side port
package fts_pkg;
    localparam int          NUM_REGS        = 8;
    localparam int          WORD_W          = 16;
    localparam int          ADDR_W          = 32;
    // register selects on the core-side port
    localparam logic [1:0]  SEL_CLASS       = 2'h0;
    localparam logic [1:0]  SEL_COND        = 2'h1;
    localparam logic [1:0]  SEL_SETUP       = 2'h2;
    localparam logic [1:0]  SEL_PTRS        = 2'h3;
    // class codes
    localparam logic [1:0]  CLS_VALID       = 2'h0;
    localparam logic [1:0]  CLS_ZERO        = 2'h1;
    localparam logic [1:0]  CLS_SPECIAL     = 2'h2;
    localparam logic [1:0]  CLS_EMPTY       = 2'h3;
    // condition word positions
    localparam int          POS_BUSY_COPY   = 15;
    localparam int          POS_CC_HI       = 14;
    localparam int          POS_TOP_LO      = 11;
    localparam int          POS_CC_LO       = 8;
    localparam int          POS_ERR_SUM     = 7;
    localparam int          POS_STK_FAULT   = 6;
    localparam int          NUM_EXC         = 6;
    // setup word positions
    localparam int          POS_ROUND_LO    = 10;
    localparam int          POS_PREC_LO     = 8;
    localparam logic [15:0] SETUP_WR_MASK   = 16'h0f3f;
    // reset values
    localparam logic [15:0] CLASS_RST       = 16'hffff;
    localparam logic [15:0] COND_RST        = 16'h0000;
    localparam logic [15:0] SETUP_RST       = 16'h033f;
    typedef enum logic [1:0] {
        FTS_RND_NEAREST,
        FTS_RND_DOWN,
        FTS_RND_UP,
        FTS_RND_TRUNC
    } fts_round_t;
    typedef enum logic [1:0] {
        FTS_PREC_24,
        FTS_PREC_RSVD,
        FTS_PREC_53,
        FTS_PREC_64
    } fts_prec_t;
endpackage

/* test/fts_core_model.sv */
// fts_core_model: integer core side of the register port
// assumes: requests launched at falling edge, answer read at the next falling edge
module fts_core_model (
    input  wire logic        clk,
    output logic             reg_wr,
    output logic [1:0]       reg_sel,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    timeunit 1ns / 1ns;
    initial {reg_wr, reg_sel, reg_wdata} = '0;
    task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] d,
                       output logic [15:0] q);
        @(negedge clk);
        reg_wr = w;
        reg_sel = s;
        reg_wdata = (s == fts_pkg::SEL_SETUP) ? (d & fts_pkg::SETUP_WR_MASK) : d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
        q = reg_rdata;
    endtask
endmodule

/* test/fts_regs_sva.sv */
// fts_regs_sva: port checks of the fpu register block
// assumes: bound to fts_regs, one clock, async active-low reset
module fts_regs_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reg_wr,
    input wire logic [1:0]  reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        top_wr,
    input wire logic [2:0]  top_val,
    input wire logic [5:0]  exc_event,
    input wire logic        stack_fault_event,
    input wire logic [1:0]  rounding_select,
    input wire logic [1:0]  precision_select,
    input wire logic        fpu_trap
);
    timeunit 1ns / 1ns;
    localparam logic [1:0] CND = fts_pkg::SEL_COND;
    localparam logic [1:0] SET = fts_pkg::SEL_SETUP;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_mirror; $past(reg_sel) == CND |-> reg_rdata[15] == reg_rdata[7]; endproperty
    a_mirror: assert property (p_mirror) else $error("bit 15 not equal bit 7");
    property p_trap; $past(reg_sel) == CND |-> fpu_trap == reg_rdata[7]; endproperty
    a_trap: assert property (p_trap) else $error("trap differs from summary");
    property p_exc; exc_event != 6'h00 && reg_sel == CND
        |=> (reg_rdata[5:0] & $past(exc_event)) == $past(exc_event); endproperty
    a_exc: assert property (p_exc) else $error("exception flag not recorded");
    property p_sf; stack_fault_event && reg_sel == CND |=> reg_rdata[6] && reg_rdata[0]; endproperty
    a_sf: assert property (p_sf) else $error("stack fault not flagged");
    property p_round; reg_wr && reg_sel == SET |=> rounding_select == $past(reg_wdata[11:10]); endproperty
    a_round: assert property (p_round) else $error("rounding select wrong");
    property p_prec; reg_wr && reg_sel == SET |=> precision_select == $past(reg_wdata[9:8]); endproperty
    a_prec: assert property (p_prec) else $error("precision select wrong");
    property p_setup; $past(reg_wr) && $past(reg_sel) == SET
        |-> reg_rdata == ($past(reg_wdata) & fts_pkg::SETUP_WR_MASK); endproperty
    a_setup: assert property (p_setup) else $error("setup readback wrong");
    property p_top; top_wr && reg_sel == CND |=> reg_rdata[13:11] == $past(top_val); endproperty
    a_top: assert property (p_top) else $error("stack top field wrong");
    c_trap: cover property (fpu_trap);
    c_sf: cover property (stack_fault_event && reg_sel == CND);
    c_set: cover property (reg_wr && reg_sel == SET);
endmodule
bind fts_regs fts_regs_sva chk (.clk, .rst_b, .reg_wr, .reg_sel, .reg_wdata, .reg_rdata,
    .top_wr, .top_val, .exc_event, .stack_fault_event, .rounding_select, .precision_select, .fpu_trap);

/* test/fts_regs_tb.sv */
// fts_regs_tb: self-checking bench of the fpu register block
// assumes: core model drives the register port, bench drives execution events
module fts_regs_tb;
    timeunit 1ns / 1ns;
    logic        clk = 0, rst_b = 0, reg_wr, fpu_trap, fpu_busy, top_wr, cc_wr, busy_in;
    logic        dreg_wr, dreg_is_zero, dreg_is_denormal, dreg_is_inf, dreg_is_nan;
    logic        dreg_is_unsupported, dreg_free, stack_fault_event, instr_issue, operand_valid;
    logic [1:0]  reg_sel, rounding_select, precision_select;
    logic [2:0]  dreg_idx, top_val;
    logic [3:0]  cc_val;
    logic [5:0]  exc_event;
    logic [15:0] reg_wdata, reg_rdata, q, d, cls;
    logic [31:0] instr_addr, operand_addr, instr_ptr, operand_ptr;
    logic [10:0] rows [8] = '{{3'h0, 6'h00, 2'h0}, {3'h1, 6'h01, 2'h1}, {3'h2, 6'h10, 2'h2},
        {3'h3, 6'h08, 2'h2}, {3'h4, 6'h04, 2'h2}, {3'h5, 6'h02, 2'h2}, {3'h6, 6'h20, 2'h3},
        {3'h7, 6'h05, 2'h2}};
    logic [15:0] rst_v [4] = '{fts_pkg::CLASS_RST, fts_pkg::COND_RST, fts_pkg::SETUP_RST, 16'h0};
    int          bad_count = 0, cmp_count = 0, cyc = 0;
    fts_regs uut (.*);
    fts_core_model m (.*);
    always #50 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic ev(input logic [5:0] e, input logic s, input logic [15:0] x, input logic t);
        @(negedge clk);
        exc_event = e;
        stack_fault_event = s;
        @(negedge clk);
        {exc_event, stack_fault_event, top_wr, cc_wr} = '0;
        m.acc(0, fts_pkg::SEL_COND, 0, q);
        chk(q, x);
        chk(fpu_trap, t);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        {dreg_wr, dreg_idx, dreg_is_zero, dreg_is_denormal, dreg_is_inf, dreg_is_nan, top_wr} = '0;
        {dreg_is_unsupported, dreg_free, stack_fault_event, instr_issue, operand_valid} = '0;
        {cc_wr, cc_val, top_val, exc_event, busy_in, instr_addr, operand_addr} = '0;
        repeat (16) @(posedge clk);
        @(negedge clk) rst_b = 1'b1;
        for (int s = 0; s < 4; s++) begin
            m.acc(0, s[1:0], 0, q);
            chk(q, rst_v[s]);
        end
        cls = 16'hffff;
        foreach (rows[i]) begin
            @(negedge clk);
            {dreg_idx, dreg_free, dreg_is_denormal, dreg_is_inf, dreg_is_nan,
                dreg_is_unsupported, dreg_is_zero} = rows[i][10:2];
            dreg_wr = 1'b1;
            @(negedge clk);
            dreg_wr = 1'b0;
            cls[2 * rows[i][10:8] +: 2] = rows[i][1:0];
            m.acc(0, fts_pkg::SEL_CLASS, 0, q);
            chk(q, cls);
        end
        for (int k = 0; k < 16; k++) begin
            d = {4'h0, k[3:0], 2'h0, 6'h2a};
            m.acc(1, fts_pkg::SEL_SETUP, d, q);
            chk(q, d);
            chk(rounding_select, k[3:2]);
            chk(precision_select, k[1:0]);
        end
        m.acc(1, fts_pkg::SEL_SETUP, 16'h033b, q);
        ev(6'h01, 0, 16'h0001, 0);
        ev(6'h04, 0, 16'h8085, 1);
        m.acc(1, fts_pkg::SEL_COND, 0, q);
        chk(q, 16'h0000);
        ev(6'h00, 1, 16'h0041, 0);
        @(negedge clk);
        {top_wr, top_val, cc_wr, cc_val, busy_in} = {1'b1, 3'h5, 1'b1, 4'ha, 1'b1};
        ev(6'h00, 0, 16'h6a41, 0);
        chk(fpu_busy, 1);
        fork
            m.acc(1, fts_pkg::SEL_COND, 0, q);
            begin
                @(negedge clk) exc_event = 6'h08;
                @(negedge clk) exc_event = 6'h00;
            end
        join
        chk(q, 16'h0008);
        @(negedge clk);
        {instr_issue, operand_valid, instr_addr, operand_addr} =
            {2'h3, 32'h1a2c_5e70, 32'h0bd4_96e8};
        @(negedge clk);
        operand_valid = 1'b0;
        chk(instr_ptr[31:16], 16'h1a2c);
        chk(operand_ptr[15:0], 16'h96e8);
        @(negedge clk);
        instr_issue = 1'b0;
        chk(instr_ptr[15:0], 16'h5e70);
        chk(operand_ptr[31:16], 16'h0000);
        @(negedge clk) rst_b = 1'b0;
        @(negedge clk) rst_b = 1'b1;
        chk(precision_select, fts_pkg::SETUP_RST[9:8]);
        m.acc(0, fts_pkg::SEL_COND, 0, q);
        chk(q, fts_pkg::COND_RST);
        tally_and_finish();
    end
endmodule
